/* rfet_pkg.sv */
// package for the rf event timer and receive guard timer
package rfet_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_GUARD = 7'h32;
  localparam logic [6:0] IDX_CFG = 7'h3f;
  localparam logic [6:0] IDX_PRESET = 7'h40;
  localparam logic [6:0] IDX_STATUS = 7'h41;
  localparam int ADDR_W = 9;
  localparam int CNT_W = 20;
  localparam int DIV_W = 8;
  // config field positions
  localparam int B_ON = 0;
  localparam int B_RELOAD = 1;
  localparam int B_SRC = 2;
  localparam int B_DIV_LO = 3;
  localparam int B_SINGLE = 6;
  localparam int B_NOW = 8;
  localparam int B_S_OWN_OFF = 10;
  localparam int B_S_OWN_ON = 11;
  localparam int B_S_FOR_OFF = 12;
  localparam int B_S_FOR_ON = 13;
  localparam int B_S_TX_END = 14;
  localparam int B_S_TX_BEG = 15;
  localparam int B_S_RX_END = 16;
  localparam int B_S_RX_BEG = 17;
  localparam int B_H_RX_ACT = 24;
  localparam int B_H_OWN_OFF = 25;
  localparam int B_H_OWN_ON = 26;
  localparam int B_H_FOR_OFF = 27;
  localparam int B_H_FOR_ON = 28;
  localparam int B_H_TX_BEG = 29;
  localparam int B_H_RX_BEG = 30;
  // writable bits of each register; start_immediately is not stored
  localparam logic [31:0] CFG_MASK = 32'h7f03_fc7f;
  localparam logic [31:0] GUARD_MASK = 32'h0fff_ffff;
  localparam logic [31:0] PRESET_MASK = 32'h000f_ffff;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] GUARD_RST = 32'h0000_0000;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  // guard register fields
  localparam int G_PRE_LO = 0;
  localparam int G_VAL_LO = 8;
  // status register fields
  localparam int S_RUN = 20;
  localparam int S_EXP = 21;
  localparam int S_GUARD = 22;

  typedef struct packed {
    logic rx_begin;
    logic rx_end;
    logic tx_begin;
    logic tx_end;
    logic foreign_field_on;
    logic foreign_field_off;
    logic own_field_on;
    logic own_field_off;
    logic rx_activity;
  } rfet_evt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } rfet_state_t;
endpackage

/* rfet_top.sv */
// rf event timer with receive guard timer and avalon register slave
//////////////////////////////////////////////////////////////////////
// Overview of operation
// - timer runs only while event_timer_on (bit 0) is set.
// - auto_reload_on clear: expiry stops the timer with count held at zero.
// - auto_reload_on set: expiry loads the preset and keeps counting down.
// - single_run_mode: no reload by a new start while the timer is running.
// - tick_source_select zero: count at the 13.56 MHz interface tick.
// - tick_source_select one: count on the prescaler output.
// - tick_divider_select picks 6.78 MHz down to 53 kHz, halving per step.
// - start_immediately starts the timer at once.
// - start_on_receive_begin starts the timer at a frame's first bit.
// - start_on_receive_end starts the timer when reception ends.
// - transmit begin and transmit end each start the timer if enabled.
// - foreign field on and off each start the timer if enabled.
// - own field on and off each start the timer if enabled.
// - halt_on_receive_begin halts the timer at a frame's first bit.
// - halt_on_transmit_begin halts the timer when transmission begins.
// - foreign field on and off each halt the timer if enabled.
// - own field on and off each halt the timer if enabled.
// - halt_on_receive_activity halts the timer on receive activity.
// - guard reload value is 20 bits; zero disables the guard time.
// - guard timer has an 8-bit prescaler reloaded from the low byte.
// - the timer preset comes from a writable 20-bit field.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rfet_top #(
  parameter int CNT_W = rfet_pkg::CNT_W,
  parameter int DIV_W = rfet_pkg::DIV_W
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [rfet_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // contactless interface
  input wire logic if_tick,
  input wire rfet_pkg::rfet_evt_t evt,
  // status
  output logic timer_running,
  output logic timer_expired,
  output logic guard_active
);
  //////////////////////////////////////////////////////////////////////
  logic [31:0] cfg_q;
  logic [31:0] guard_cfg_q;
  logic [31:0] preset_q;
  logic wait_q;
  logic now_q;
  logic exp_flag_q;
  rfet_pkg::rfet_state_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] g_pre_q;
  logic [CNT_W-1:0] g_cnt_q;
  logic [31:0] wmask;
  logic [6:0] idx;
  logic hit_ok;
  logic req;
  logic acc;
  logic wr_cfg;
  logic [2:0] div_sel;
  logic [DIV_W-1:0] div_mask;
  logic pre_tick;
  logic tick;
  logic start_hit;
  logic stop_hit;
  logic run;
  logic exp_now;
  logic [CNT_W-1:0] preset;
  logic [CNT_W-1:0] g_val;
  logic [DIV_W-1:0] g_pre;
  logic clr_exp;

  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign idx = avs_address[rfet_pkg::ADDR_W-1:2];
  assign hit_ok = avs_address[1:0] == 2'h0;
  assign req = avs_read | avs_write;
  // request is taken at the edge where waitrequest is seen low
  assign acc = ce & req & ~wait_q;
  assign wr_cfg = acc & avs_write & hit_ok & (idx == rfet_pkg::IDX_CFG);
  assign clr_exp = acc & avs_write & hit_ok & (idx == rfet_pkg::IDX_STATUS)
                   & avs_byteenable[2] & avs_writedata[rfet_pkg::S_EXP];
  assign run = st_q == rfet_pkg::ST_RUN;
  assign preset = preset_q[CNT_W-1:0];
  assign g_val = guard_cfg_q[rfet_pkg::G_VAL_LO +: CNT_W];
  assign g_pre = guard_cfg_q[rfet_pkg::G_PRE_LO +: DIV_W];

  //////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a one-cycle acknowledge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else if (ce) begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && wait_q) begin
      if (!hit_ok) begin
        avs_readdata <= 32'h0000_0000;
      end else begin
        unique case (idx)
          rfet_pkg::IDX_GUARD: avs_readdata <= guard_cfg_q;
          rfet_pkg::IDX_CFG: avs_readdata <= cfg_q;
          rfet_pkg::IDX_PRESET: avs_readdata <= preset_q;
          rfet_pkg::IDX_STATUS: begin
            avs_readdata <= 32'h0000_0000;
            avs_readdata[CNT_W-1:0] <= cnt_q;
            avs_readdata[rfet_pkg::S_RUN] <= run;
            avs_readdata[rfet_pkg::S_EXP] <= exp_flag_q;
            avs_readdata[rfet_pkg::S_GUARD] <= guard_active;
          end
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= ~(req & wait_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= rfet_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= (cfg_q & ~(wmask & rfet_pkg::CFG_MASK)) | (avs_writedata & wmask & rfet_pkg::CFG_MASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      guard_cfg_q <= rfet_pkg::GUARD_RST;
    end else if (acc && avs_write && hit_ok && idx == rfet_pkg::IDX_GUARD) begin
      guard_cfg_q <= (guard_cfg_q & ~(wmask & rfet_pkg::GUARD_MASK))
                     | (avs_writedata & wmask & rfet_pkg::GUARD_MASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      preset_q <= rfet_pkg::PRESET_RST;
    end else if (acc && avs_write && hit_ok && idx == rfet_pkg::IDX_PRESET) begin
      preset_q <= (preset_q & ~(wmask & rfet_pkg::PRESET_MASK))
                  | (avs_writedata & wmask & rfet_pkg::PRESET_MASK);
    end
  end

  // start_immediately is a write strobe, it reads back as zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      now_q <= 1'b0;
    end else if (ce) begin
      now_q <= wr_cfg & avs_byteenable[1] & avs_writedata[rfet_pkg::B_NOW];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // tick source: divide the interface tick by 2 << tick_divider_select
  assign div_sel = cfg_q[rfet_pkg::B_DIV_LO +: 3];
  assign div_mask = DIV_W'((9'h002 << div_sel) - 9'h001);
  assign pre_tick = if_tick & ((div_q & div_mask) == div_mask);
  assign tick = cfg_q[rfet_pkg::B_SRC] ? pre_tick : if_tick;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_q <= '0;
    end else if (ce && if_tick) begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // start and halt events
  always_comb begin
    start_hit = now_q;
    start_hit |= cfg_q[rfet_pkg::B_S_RX_BEG] & evt.rx_begin;
    start_hit |= cfg_q[rfet_pkg::B_S_RX_END] & evt.rx_end;
    start_hit |= cfg_q[rfet_pkg::B_S_TX_BEG] & evt.tx_begin;
    start_hit |= cfg_q[rfet_pkg::B_S_TX_END] & evt.tx_end;
    start_hit |= cfg_q[rfet_pkg::B_S_FOR_ON] & evt.foreign_field_on;
    start_hit |= cfg_q[rfet_pkg::B_S_FOR_OFF] & evt.foreign_field_off;
    start_hit |= cfg_q[rfet_pkg::B_S_OWN_ON] & evt.own_field_on;
    start_hit |= cfg_q[rfet_pkg::B_S_OWN_OFF] & evt.own_field_off;
  end

  always_comb begin
    stop_hit = cfg_q[rfet_pkg::B_H_RX_BEG] & evt.rx_begin;
    stop_hit |= cfg_q[rfet_pkg::B_H_TX_BEG] & evt.tx_begin;
    stop_hit |= cfg_q[rfet_pkg::B_H_FOR_ON] & evt.foreign_field_on;
    stop_hit |= cfg_q[rfet_pkg::B_H_FOR_OFF] & evt.foreign_field_off;
    stop_hit |= cfg_q[rfet_pkg::B_H_OWN_ON] & evt.own_field_on;
    stop_hit |= cfg_q[rfet_pkg::B_H_OWN_OFF] & evt.own_field_off;
    stop_hit |= cfg_q[rfet_pkg::B_H_RX_ACT] & evt.rx_activity;
  end

  // expiry on the tick that takes the count to zero
  assign exp_now = run & cfg_q[rfet_pkg::B_ON] & ~stop_hit & tick & (cnt_q <= CNT_W'(1));

  //////////////////////////////////////////////////////////////////////
  // main timer; a halt beats a start in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= rfet_pkg::ST_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      if (!cfg_q[rfet_pkg::B_ON]) begin
        st_q <= rfet_pkg::ST_IDLE;
      end else if (stop_hit) begin
        st_q <= rfet_pkg::ST_IDLE;
      end else if (start_hit && !(run && cfg_q[rfet_pkg::B_SINGLE])) begin
        st_q <= rfet_pkg::ST_RUN;
        cnt_q <= preset;
      end else if (exp_now && cfg_q[rfet_pkg::B_RELOAD]) begin
        cnt_q <= preset;
      end else if (exp_now) begin
        st_q <= rfet_pkg::ST_IDLE;
        cnt_q <= '0;
      end else if (run && tick) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // sticky expiry flag, write one to clear; a new expiry wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      exp_flag_q <= 1'b0;
    end else if (ce) begin
      exp_flag_q <= exp_now | (exp_flag_q & ~clr_exp);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_expired <= 1'b0;
      timer_running <= 1'b0;
    end else if (ce) begin
      timer_expired <= exp_now;
      timer_running <= run;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive guard: armed at transmit end, blocks the receiver until done
  always_ff @(posedge core_clk) begin
    if (srst) begin
      g_cnt_q <= '0;
      g_pre_q <= '0;
      guard_active <= 1'b0;
    end else if (ce) begin
      if (g_val == '0) begin
        guard_active <= 1'b0;
        g_cnt_q <= '0;
      end else if (evt.tx_end) begin
        guard_active <= 1'b1;
        g_cnt_q <= g_val;
        g_pre_q <= g_pre;
      end else if (guard_active && if_tick) begin
        if (g_pre_q != '0) begin
          g_pre_q <= g_pre_q - DIV_W'(1);
        end else begin
          g_pre_q <= g_pre;
          g_cnt_q <= g_cnt_q - CNT_W'(1);
          guard_active <= g_cnt_q > CNT_W'(1);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  a_disabled_idle: assert property (@(posedge core_clk) disable iff (srst)
    ce && !cfg_q[rfet_pkg::B_ON] |=> !run)
    else $error("timer runs while disabled");

  a_stop_at_zero: assert property (@(posedge core_clk) disable iff (srst)
    ce && exp_now && !start_hit && !cfg_q[rfet_pkg::B_RELOAD] |=> !run && cnt_q == '0)
    else $error("timer did not stop at zero");

  a_reload_expiry: assert property (@(posedge core_clk) disable iff (srst)
    ce && exp_now && cfg_q[rfet_pkg::B_RELOAD] |=> run && cnt_q == $past(preset))
    else $error("timer did not reload on expiry");

  a_single_no_reload: assert property (@(posedge core_clk) disable iff (srst)
    ce && run && cfg_q[rfet_pkg::B_SINGLE] && cfg_q[rfet_pkg::B_ON] && !stop_hit && !tick
    |=> cnt_q == $past(cnt_q))
    else $error("single run timer reloaded early");

  a_fast_decrement: assert property (@(posedge core_clk) disable iff (srst)
    ce && run && !cfg_q[rfet_pkg::B_SRC] && if_tick && cnt_q > CNT_W'(1) && !start_hit && !stop_hit
    && cfg_q[rfet_pkg::B_ON] |=> cnt_q == $past(cnt_q) - CNT_W'(1))
    else $error("count missed interface tick");

  a_divided_tick: assert property (@(posedge core_clk) disable iff (srst)
    ce && cfg_q[rfet_pkg::B_SRC] && div_sel == 3'h0 && if_tick && div_q[0] == 1'b0 && run
    && !start_hit && !stop_hit && cfg_q[rfet_pkg::B_ON] |=> cnt_q == $past(cnt_q))
    else $error("prescaled timer counted on an odd tick");

  a_start_now: assert property (@(posedge core_clk) disable iff (srst)
    ce && wr_cfg && avs_byteenable[1] && avs_writedata[rfet_pkg::B_NOW] && avs_writedata[rfet_pkg::B_ON]
    && avs_byteenable[0] ##1 ce && !stop_hit && !run |=> run && cnt_q == $past(preset))
    else $error("immediate start failed");

  a_halt_event: assert property (@(posedge core_clk) disable iff (srst)
    ce && stop_hit |=> !run ##1 !timer_running)
    else $error("halt event ignored");

  a_guard_off: assert property (@(posedge core_clk) disable iff (srst)
    ce && g_val == '0 |=> !guard_active)
    else $error("guard active with zero value");

  // reset still acts while ce is low, so only a held enable promises frozen state
  a_frozen_state: assert property (@(posedge core_clk) disable iff (srst)
    !ce |=> $stable(cnt_q) && $stable(st_q) && $stable(g_cnt_q) && $stable(avs_waitrequest))
    else $error("state moved with clock enable low");

  a_one_wait: assert property (@(posedge core_clk) disable iff (srst)
    ce && (req || !avs_waitrequest) |=> avs_waitrequest == !$past(avs_waitrequest))
    else $error("bus answer not after one wait cycle");

  a_prescale_hold: assert property (@(posedge core_clk) disable iff (srst)
    ce && run && cfg_q[rfet_pkg::B_SRC] && !pre_tick && !start_hit && !stop_hit
    |=> cnt_q == $past(cnt_q))
    else $error("prescaled timer counted without a divided tick");

  a_event_start: assert property (@(posedge core_clk) disable iff (srst)
    ce && cfg_q[rfet_pkg::B_ON] && start_hit && !stop_hit && !run |=> run && cnt_q == $past(preset))
    else $error("start event did not load the preset");

  a_tick_decrement: assert property (@(posedge core_clk) disable iff (srst)
    ce && run && tick && cnt_q > CNT_W'(1) && !start_hit && !stop_hit && cfg_q[rfet_pkg::B_ON]
    |=> cnt_q == $past(cnt_q) - CNT_W'(1))
    else $error("count missed a selected tick");

  a_expiry_pulse: assert property (@(posedge core_clk) disable iff (srst)
    ce && exp_now |=> timer_expired && exp_flag_q)
    else $error("expiry not flagged");

  a_guard_arm: assert property (@(posedge core_clk) disable iff (srst)
    ce && g_val != '0 && evt.tx_end |=> guard_active && g_cnt_q == $past(g_val) && g_pre_q == $past(g_pre))
    else $error("guard did not load its reload values");

  a_guard_prescale: assert property (@(posedge core_clk) disable iff (srst)
    ce && guard_active && if_tick && g_val != '0 && !evt.tx_end && g_pre_q != '0
    |=> g_cnt_q == $past(g_cnt_q) && g_pre_q == $past(g_pre_q) - DIV_W'(1))
    else $error("guard prescaler did not step");

  a_guard_step: assert property (@(posedge core_clk) disable iff (srst)
    ce && guard_active && if_tick && g_val != '0 && !evt.tx_end && g_pre_q == '0
    |=> g_cnt_q == $past(g_cnt_q) - CNT_W'(1) && g_pre_q == $past(g_pre))
    else $error("guard count did not step");
endmodule
`default_nettype wire

/* rfet_top_tb.sv */
// self-checking bench for the rf event timer and receive guard timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module rfet_top_tb;
  logic core_clk, srst, ce, avs_read, avs_write, if_tick;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, timer_running, timer_expired, guard_active;
  rfet_pkg::rfet_evt_t evt;
  int n_errors, cmp_count, n_exp;
  localparam logic [8:0] A_GRD = {rfet_pkg::IDX_GUARD, 2'b00};
  localparam logic [8:0] A_CFG = {rfet_pkg::IDX_CFG, 2'b00};
  localparam logic [8:0] A_PRE = {rfet_pkg::IDX_PRESET, 2'b00};
  localparam logic [8:0] A_ST = {rfet_pkg::IDX_STATUS, 2'b00};
  localparam logic [31:0] ON = 32'h1 << rfet_pkg::B_ON;
  localparam logic [31:0] RLD = 32'h1 << rfet_pkg::B_RELOAD;
  localparam logic [31:0] SRC = 32'h1 << rfet_pkg::B_SRC;
  localparam logic [31:0] SGL = 32'h1 << rfet_pkg::B_SINGLE;
  localparam logic [31:0] NOW = 32'h1 << rfet_pkg::B_NOW;
  localparam logic [31:0] STB = 32'h1 << rfet_pkg::B_S_TX_BEG;
  logic [8:0] ra [3] = '{A_GRD, A_CFG, A_PRE};
  logic [31:0] rm [3] = '{rfet_pkg::GUARD_MASK, rfet_pkg::CFG_MASK, rfet_pkg::PRESET_MASK};
  int hb [7] = '{30, 29, 28, 27, 26, 25, 24};
  int eb [7] = '{8, 6, 4, 3, 2, 1, 0};

  rfet_top DUT (
    .core_clk(core_clk), .srst(srst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .if_tick(if_tick), .evt(evt),
    .timer_running(timer_running), .timer_expired(timer_expired), .guard_active(guard_active)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // counts cycles with the expiry pulse high, so a stretched pulse shows up too
  always @(posedge core_clk) begin
    if (timer_expired === 1'b1) n_exp++;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [8:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  // config write, then room for the start strobe to load the count
  task automatic go(input logic [31:0] c);
    wr(A_CFG, c);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      if_tick <= 1'b1;
      @(posedge core_clk);
      if_tick <= 1'b0;
    end
  endtask

  task automatic pulse(input logic [8:0] e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    repeat (2) @(posedge core_clk);
  endtask

  function automatic logic [31:0] st(input logic [19:0] c, input logic r, input logic x);
    return {10'h0, x, r, c};
  endfunction

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    if_tick = 1'b0;
    evt = '0;
    n_errors = 0;
    cmp_count = 0;
    n_exp = 0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(ra[i]);
      `CHK("reset value", 32'h0, q)
      wr(ra[i], 32'hffff_ffff);
      rd(ra[i]);
      `CHK("writable bits", rm[i], q)
    end
    wr(A_CFG, 32'h0);
    wr(A_GRD, 32'h0);
    bus(1'b1, A_PRE, 32'h0, 4'h1);
    rd(A_PRE);
    `CHK("byte lanes", 32'h000f_ff00, q)
    wr(A_PRE | 9'h1, 32'h5);
    rd(A_PRE | 9'h1);
    `CHK("misaligned", 32'h0, q)
    rd({7'h10, 2'b00});
    `CHK("unmapped", 32'h0, q)
    rd(A_PRE);
    `CHK("preset kept", 32'h000f_ff00, q)
    test_end("registers");
    wr(A_PRE, 32'h3);
    go(ON | NOW);
    rd(A_ST);
    `CHK("loaded", st(3, 1, 0), q)
    `CHK("running port", 1'b1, timer_running)
    tick(2);
    rd(A_ST);
    `CHK("decrement", st(1, 1, 0), q)
    tick(3);
    rd(A_ST);
    `CHK("stopped at zero", st(0, 0, 1), q)
    `CHK("expiry pulses", 1, n_exp)
    wr(A_ST, 32'h0020_0000);
    rd(A_ST);
    `CHK("expiry cleared", st(0, 0, 0), q)
    wr(A_PRE, 32'h4);
    go(ON | NOW);
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    rd(A_ST);
    `CHK("frozen count", st(4, 1, 0), q)
    wr(A_PRE, 32'h2);
    go(ON | RLD | NOW);
    tick(2);
    rd(A_ST);
    `CHK("reloaded", st(2, 1, 1), q)
    tick(2);
    // the pulse of the last expiry is counted one edge after it is launched
    repeat (2) @(posedge core_clk);
    `CHK("reload expiries", 3, n_exp)
    go(NOW | STB);
    pulse(9'h1ff);
    rd(A_ST);
    `CHK("disabled", 1'b0, q[20])
    wr(A_ST, 32'h0020_0000);
    test_end("expiry");
    wr(A_PRE, 32'hf_ffff);
    for (int i = 10; i < 18; i++) begin
      go(ON | (32'h1 << i));
      pulse(~(9'h1 << (i - 9)) & 9'h1fe);
      rd(A_ST);
      `CHK("other events", 1'b0, q[20])
      pulse(9'h1 << (i - 9));
      rd(A_ST);
      `CHK("started", 1'b1, q[20])
      go(32'h0);
    end
    test_end("start events");
    for (int i = 0; i < 7; i++) begin
      go(ON | NOW | (32'h1 << hb[i]));
      pulse(~(9'h1 << eb[i]));
      rd(A_ST);
      `CHK("not halted", 1'b1, q[20])
      pulse(9'h1 << eb[i]);
      rd(A_ST);
      `CHK("halted", 1'b0, q[20])
      go(32'h0);
    end
    test_end("halt events");
    for (int s = 0; s < 2; s++) begin
      wr(A_PRE, 32'h5);
      go(ON | NOW | STB | (s != 0 ? SGL : 32'h0));
      tick(2);
      pulse(9'h040);
      rd(A_ST);
      `CHK("restart count", (s != 0 ? 20'h3 : 20'h5), q[19:0])
      go(32'h0);
    end
    test_end("single run");
    wr(A_PRE, 32'hf_ffff);
    for (int s = 0; s < 8; s++) begin
      go(ON | SRC | NOW | (32'(s) << rfet_pkg::B_DIV_LO));
      tick(4 << s);
      rd(A_ST);
      `CHK("prescaled count", 20'hf_fffd, q[19:0])
      go(32'h0);
    end
    test_end("prescaler");
    for (int p = 1; p < 32; p += 15) begin
      wr(A_GRD, 32'h0000_0200 | 32'(p));
      pulse(9'h020);
      `CHK("guard armed", 1'b1, guard_active)
      tick(p);
      rd(A_ST);
      `CHK("guard status", 1'b1, q[22])
      tick(4 * p + 4);
      `CHK("guard done", 1'b0, guard_active)
    end
    pulse(9'h020);
    wr(A_GRD, 32'h0000_00ff);
    repeat (2) @(posedge core_clk);
    `CHK("guard off", 1'b0, guard_active)
    pulse(9'h020);
    `CHK("guard stays off", 1'b0, guard_active)
    test_end("guard");
    finish_test;
  end

  // the whole sequence needs about 3300 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] run length exp 30000 got more");
    finish_test;
  end
endmodule
`default_nettype wire
